// ===== spc_pkg.sv
package spc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_BUF = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;

    localparam int BIT_WRITE_COLLISION_FLAG = 7;
    localparam int BIT_OVF = 6;
    localparam int BIT_EN = 5;
    localparam int BIT_CKP = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BUF_RESET = 8'h00;

    localparam int STAT_FULL = 0;
    localparam int STAT_BUSY = 1;

    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVF = 1;
    localparam int IRQ_WRITE_COLLISION_FLAG = 2;
    localparam int IRQ_START = 3;
    localparam int IRQ_STOP = 4;
    localparam int IRQ_W = 5;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Modes and timing
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_SPIM_DIV4 = 4'b0000,
        MODE_SPIM_DIV16 = 4'b0001,
        MODE_SPIM_DIV64 = 4'b0010,
        MODE_SPIM_TMR = 4'b0011,
        MODE_SPIS_SS = 4'b0100,
        MODE_SPIS_NOSS = 4'b0101,
        MODE_I2C_S7 = 4'b0110,
        MODE_I2C_S10 = 4'b0111,
        MODE_I2C_FWM = 4'b1011,
        MODE_I2C_S7_SP = 4'b1110
    } spc_mode_e;

    // Half bit periods, in clock cycles, for the oscillator-derived clocks.
    localparam logic [5:0] HALF_DIV4 = 6'd2;
    localparam logic [5:0] HALF_DIV16 = 6'd8;
    localparam logic [5:0] HALF_DIV64 = 6'd32;
    localparam logic [3:0] BYTE_BITS = 4'd8;

    function automatic logic is_spi_master(input logic [3:0] m);
        return m[3:2] == 2'b00;
    endfunction : is_spi_master

    function automatic logic is_spi_slave(input logic [3:0] m);
        return (m == MODE_SPIS_SS) || (m == MODE_SPIS_NOSS);
    endfunction : is_spi_slave

    function automatic logic is_i2c(input logic [3:0] m);
        return (m == MODE_I2C_S7) || (m == MODE_I2C_S10) || (m == MODE_I2C_FWM) ||
               (m == MODE_I2C_S7_SP);
    endfunction : is_i2c

endpackage : spc_pkg

// ===== spc_clkdiv.sv
`timescale 1ns/100ps
`default_nettype none
module spc_clkdiv
    import spc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [3:0] mode,
    input wire logic timer_two_tick,
    output logic tick
);

    logic [5:0] cnt_r;
    logic [5:0] half;

    always_comb begin
        case (mode)
            MODE_SPIM_DIV16: half = HALF_DIV16;
            MODE_SPIM_DIV64: half = HALF_DIV64;
            default: half = HALF_DIV4;
        endcase
    end

    // A tick marks each serial clock edge; the timer source halves to one bit per two ticks.
    always_comb begin
        if (!run) begin
            tick = 1'b0;
        end else if (mode == MODE_SPIM_TMR) begin
            tick = timer_two_tick;
        end else begin
            tick = (cnt_r == half - 6'd1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 6'd0;
        end else if (!run || tick) begin
            cnt_r <= 6'd0;
        end else begin
            cnt_r <= cnt_r + 6'd1;
        end
    end

endmodule : spc_clkdiv
`default_nettype wire

// ===== spc_top.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module spc_top
    import spc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic timer_two_tick,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe,
    input wire logic ss_n_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic pins_to_gpio,
    output logic irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [7:0] rx_buf_r;
    logic buf_full_r;
    logic [7:0] shreg_r;
    logic [3:0] bitcnt_r;
    logic samp_r;
    logic mbusy_r;
    logic sck_r;
    logic lead_r;
    logic sck_prev_r;
    logic sda_prev_r;
    logic i2c_frame_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_en_r;

    logic [7:0] aw_addr_r;
    logic aw_have_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic w_have_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    logic [3:0] mode;
    logic enable;
    logic cpol;
    logic m_spi;
    logic s_spi;
    logic m_i2c;
    logic ss_ok;
    logic tick;
    logic do_write;
    logic do_read;
    logic buf_wr;
    logic buf_rd;
    logic ctrl_wr;
    logic busy;
    logic write_collision_flag_ev;
    logic done_ev;
    logic ovf_ev;
    logic start_ev;
    logic stop_ev;
    logic s_lead;
    logic i2c_rise;
    logic [7:0] shifted;

    assign mode = ctrl_r[3:0];
    assign enable = ctrl_r[BIT_EN];
    assign cpol = ctrl_r[BIT_CKP];
    assign m_spi = enable && is_spi_master(mode);
    assign s_spi = enable && is_spi_slave(mode);
    assign m_i2c = enable && is_i2c(mode);
    assign ss_ok = (mode != MODE_SPIS_SS) || !ss_n_in;

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready = !w_have_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    assign do_write = aw_have_r && w_have_r && !bvalid_r;
    assign do_read = s_axi_arvalid && !rvalid_r;
    assign buf_wr = do_write && (aw_addr_r == ADDR_BUF) && w_strb_r[0];
    assign ctrl_wr = do_write && (aw_addr_r == ADDR_CTRL) && w_strb_r[0];
    assign buf_rd = do_read && (s_axi_araddr == ADDR_BUF);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_have_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (do_write) begin
            w_have_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            case (aw_addr_r)
                ADDR_BUF, ADDR_STAT, ADDR_IRQ_STAT, ADDR_IRQ_CLR, ADDR_IRQ_EN,
                ADDR_CTRL: bresp_r <= RESP_OKAY;
                default: bresp_r <= RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (do_read) begin
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            case (s_axi_araddr)
                ADDR_BUF: rdata_r <= {24'h00_0000, rx_buf_r};
                ADDR_STAT: rdata_r <= {30'h0000_0000, busy, buf_full_r};
                ADDR_IRQ_STAT: rdata_r <= {27'h000_0000, irq_stat_r};
                ADDR_IRQ_CLR: rdata_r <= 32'h0000_0000;
                ADDR_IRQ_EN: rdata_r <= {27'h000_0000, irq_en_r};
                ADDR_CTRL: rdata_r <= {24'h00_0000, ctrl_r};
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    // Hardware-set flags win over a software write in the same cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RESET;
        end else begin
            if (ctrl_wr) begin
                ctrl_r <= w_data_r[7:0];
            end
            if (write_collision_flag_ev) begin
                ctrl_r[BIT_WRITE_COLLISION_FLAG] <= 1'b1;
            end
            if (ovf_ev) begin
                ctrl_r[BIT_OVF] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive buffer and collision detection
    // ----------------------------------------------------------------
    assign busy = mbusy_r || (s_spi && bitcnt_r != 4'd0);
    assign write_collision_flag_ev = buf_wr && busy && !m_i2c;
    assign shifted = {shreg_r[6:0], s_spi ? sdi_in : samp_r};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_buf_r <= BUF_RESET;
            buf_full_r <= 1'b0;
        end else if (done_ev && !ovf_ev) begin
            rx_buf_r <= m_i2c ? shreg_r : shifted;
            buf_full_r <= 1'b1;
        end else if (buf_rd) begin
            buf_full_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Bit clock generation
    // ----------------------------------------------------------------
    spc_clkdiv u_clkdiv (
        .clk(clk),
        .rst_n(rst_n),
        .run(mbusy_r),
        .mode(mode),
        .timer_two_tick(timer_two_tick),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // Shift engine
    // ----------------------------------------------------------------
    assign s_lead = s_spi && ss_ok && (sck_prev_r == cpol) && (sck_in != cpol);
    assign i2c_rise = m_i2c && i2c_frame_r && !sck_prev_r && sck_in;
    assign start_ev = m_i2c && sck_in && sda_prev_r && !sda_in;
    assign stop_ev = m_i2c && sck_in && !sda_prev_r && sda_in;

    always_comb begin
        done_ev = 1'b0;
        if (m_spi) begin
            done_ev = tick && !lead_r && bitcnt_r == BYTE_BITS - 4'd1;
        end else if (s_spi) begin
            done_ev = s_lead && bitcnt_r == BYTE_BITS - 4'd1;
        end else if (m_i2c) begin
            done_ev = i2c_rise && bitcnt_r == BYTE_BITS;
        end
    end

    // The master overwrites the previous byte; only slave and I2C modes overflow.
    assign ovf_ev = done_ev && buf_full_r && !m_spi;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_r <= 1'b0;
            sda_prev_r <= 1'b1;
        end else begin
            sck_prev_r <= sck_in;
            sda_prev_r <= sda_in;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            i2c_frame_r <= 1'b0;
        end else if (!m_i2c || stop_ev) begin
            i2c_frame_r <= 1'b0;
        end else if (start_ev) begin
            i2c_frame_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg_r <= BUF_RESET;
            bitcnt_r <= 4'd0;
            samp_r <= 1'b0;
            mbusy_r <= 1'b0;
            lead_r <= 1'b1;
        end else if (m_spi) begin
            if (!mbusy_r) begin
                if (buf_wr) begin
                    shreg_r <= w_data_r[7:0];
                    bitcnt_r <= 4'd0;
                    mbusy_r <= 1'b1;
                    lead_r <= 1'b1;
                end
            end else if (tick) begin
                lead_r <= !lead_r;
                if (lead_r) begin
                    samp_r <= sdi_in;
                end else begin
                    shreg_r <= shifted;
                    bitcnt_r <= bitcnt_r + 4'd1;
                    if (bitcnt_r == BYTE_BITS - 4'd1) begin
                        mbusy_r <= 1'b0;
                        bitcnt_r <= 4'd0;
                    end
                end
            end
        end else if (s_spi) begin
            mbusy_r <= 1'b0;
            if (!ss_ok) begin
                bitcnt_r <= 4'd0;
            end else if (s_lead) begin
                shreg_r <= shifted;
                bitcnt_r <= (bitcnt_r == BYTE_BITS - 4'd1) ? 4'd0 : bitcnt_r + 4'd1;
            end else if (buf_wr && bitcnt_r == 4'd0) begin
                shreg_r <= w_data_r[7:0];
            end
        end else if (m_i2c) begin
            mbusy_r <= 1'b0;
            if (start_ev || !i2c_frame_r) begin
                bitcnt_r <= 4'd0;
            end else if (i2c_rise) begin
                if (bitcnt_r == BYTE_BITS) begin
                    bitcnt_r <= 4'd0;
                end else begin
                    shreg_r <= {shreg_r[6:0], sda_in};
                    bitcnt_r <= bitcnt_r + 4'd1;
                end
            end
        end else begin
            mbusy_r <= 1'b0;
            bitcnt_r <= 4'd0;
        end
    end

    // ----------------------------------------------------------------
    // Serial clock output
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_r <= 1'b0;
        end else if (!mbusy_r) begin
            sck_r <= cpol;
        end else if (tick) begin
            sck_r <= !sck_r;
        end
    end

    // ----------------------------------------------------------------
    // Pin ownership
    // ----------------------------------------------------------------
    always_comb begin
        sck_out = 1'b0;
        sck_oe = 1'b0;
        sdo_out = 1'b0;
        sdo_oe = 1'b0;
        sda_out = 1'b0;
        sda_oe = 1'b0;
        if (m_spi) begin
            sck_out = sck_r;
            sck_oe = 1'b1;
            sdo_out = shreg_r[7];
            sdo_oe = 1'b1;
        end else if (s_spi) begin
            sdo_out = shreg_r[7];
            sdo_oe = ss_ok;
        end else if (m_i2c) begin
            sck_oe = !cpol;
        end
    end

    assign pins_to_gpio = !enable;

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    logic [IRQ_W-1:0] irq_ev;
    logic [IRQ_W-1:0] irq_clr;

    // Start and stop events only raise interrupts in the dedicated mode.
    assign irq_ev = {stop_ev && mode == MODE_I2C_S7_SP,
                     start_ev && mode == MODE_I2C_S7_SP, write_collision_flag_ev, ovf_ev,
                     done_ev && !ovf_ev};
    assign irq_clr = (do_write && aw_addr_r == ADDR_IRQ_CLR && w_strb_r[0]) ?
                     w_data_r[IRQ_W-1:0] : IRQ_RESET;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r <= IRQ_RESET;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_r <= IRQ_RESET;
        end else if (do_write && aw_addr_r == ADDR_IRQ_EN && w_strb_r[0]) begin
            irq_en_r <= w_data_r[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_r & irq_en_r);

endmodule : spc_top
`default_nettype wire

// ===== spc_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module spc_assertions
    import spc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic sdo_oe,
    input wire logic pins_to_gpio
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
    chk_b_gate: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_r_gate: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    chk_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    chk_pins_gpio: assert property (pins_to_gpio |-> !sck_oe && !sdo_oe)
        else $error("pin driven while port disabled");
    chk_sck_half: assert property (sck_oe && $changed(sck_out) |=> $stable(sck_out))
        else $error("serial clock half period too short");
    chk_i2c_hold: assert property (sck_oe && !sdo_oe |-> !sck_out)
        else $error("held clock line not low");

    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    cover property (sck_oe && sdo_oe && $changed(sck_out));
    cover property (sck_oe && !sdo_oe);
endmodule : spc_assertions

bind spc_top spc_assertions chk_u (.*);
`default_nettype wire

// ===== spc_peer.sv
`timescale 1ns/100ps
`default_nettype none
module spc_peer (
    input wire logic clk,
    input wire logic cpol,
    input wire logic sck_in,
    input wire logic sdo_out,
    output logic sck_drv,
    output logic sdi_in,
    output logic sda_in,
    output logic ss_n_in
);
    logic [7:0] tx = 8'h00, rx = 8'h00, ld_b = 8'h00;
    logic ld = 1'b0, sck_q = 1'b0;
    int bits = 0;

    initial begin
        sck_drv = 1'b0;
        sdi_in = 1'b0;
        sda_in = 1'b1;
        ss_n_in = 1'b1;
    end

    // ----------------------------------------------------------------
    // Peer shifter
    // ----------------------------------------------------------------
    // Samples on leading edges, shifts on trailing ones; idle data wanders.
    always @(posedge clk) begin
        sck_q <= sck_in;
        if (ld) begin
            tx <= ld_b;
            sdi_in <= ld_b[7];
            bits <= 8;
            ld <= 1'b0;
        end else if (sck_in !== sck_q && sck_in !== cpol) begin
            rx <= {rx[6:0], sdo_out};
        end else if (sck_in !== sck_q && bits > 0) begin
            tx <= {tx[6:0], 1'b0};
            sdi_in <= tx[6];
            bits <= bits - 1;
        end else if (bits == 0) begin
            sdi_in <= !sdi_in;
        end
    end

    task automatic load(input logic [7:0] b);
        @(posedge clk);
        ld_b <= b;
        ld <= 1'b1;
    endtask : load

    task automatic frame(input logic [7:0] b);
        load(b);
        ss_n_in <= 1'b0;
        repeat (8) begin
            repeat (4) @(posedge clk);
            sck_drv <= !cpol;
            repeat (4) @(posedge clk);
            sck_drv <= cpol;
        end
        repeat (4) @(posedge clk);
        ss_n_in <= 1'b1;
    endtask : frame

    // Start, eight bits msb first, then a released ack slot; data moves while scl is low.
    task automatic i2c(input logic [7:0] b);
        repeat (2) @(posedge clk);
        sck_drv <= 1'b1;
        repeat (2) @(posedge clk);
        sda_in <= 1'b0;
        for (int k = 8; k >= 0; k--) begin
            repeat (2) @(posedge clk);
            sck_drv <= 1'b0;
            repeat (2) @(posedge clk);
            sda_in <= (k > 0) ? b[k-1] : 1'b1;
            repeat (2) @(posedge clk);
            sck_drv <= 1'b1;
        end
        repeat (2) @(posedge clk);
        sck_drv <= 1'b0;
    endtask : i2c
endmodule : spc_peer
`default_nettype wire

// ===== sync_serial_port_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sync_serial_port_control_tb;
    import spc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, cpol = 1'b0, sck_q = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rdat;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, timer_two_tick = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata;
    logic sck_out, sck_oe, sdo_out, sdo_oe, sda_out, sda_oe, pins_to_gpio, irq;
    logic sck_drv, sdi_in, ss_n_in, sda_in;
    wire sck_in = sck_oe ? sck_out : sck_drv;
    int mismatches = 0, checks_done = 0, edges = 0, gap = 0, lastgap = 0, tdiv = 0, e0;
    logic [7:0] gaps [4] = '{8'(HALF_DIV4), 8'(HALF_DIV16), 8'(HALF_DIV64), 8'd3};
    logic [7:0] i2c_modes [4] = '{8'h06, 8'h07, 8'h0b, 8'h0e};

    spc_top dut_u (.*);
    spc_peer peer_u (.*);

    always #4 clk = !clk;

    // ----------------------------------------------------------------
    // Timer pulse every third cycle and serial clock edge monitor
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        tdiv <= (tdiv == 2) ? 0 : tdiv + 1;
        timer_two_tick <= (tdiv == 2);
        sck_q <= sck_out;
        gap <= (sck_oe && sck_out !== sck_q) ? 1 : gap + 1;
        if (sck_oe && sck_out !== sck_q) begin
            edges <= edges + 1;
            lastgap <= gap;
        end
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task automatic hang;
        mismatches++;
        $display("unexpected at %0t: wait timed out", $time);
        give_verdict();
    endtask : hang

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= we;
        s_axi_wvalid <= we;
        s_axi_arvalid <= !we;
        s_axi_bready <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while ((we ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && n < 50);
        rsp = we ? s_axi_bresp : s_axi_rresp;
        rdat = s_axi_rdata[7:0];
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (n >= 50) hang();
    endtask : bus

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            bus(1'b0, ADDR_STAT, 8'h00);
            n++;
        end while (rdat[STAT_BUSY] !== 1'b0 && n < 400);
        if (n >= 400) hang();
    endtask : wait_idle

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, ADDR_CTRL, 8'h00);
        chk(rdat, CTRL_RESET, "ctrl reset");
        chk({7'h0, pins_to_gpio}, 8'h01, "gpio at reset");
        bus(1'b0, 8'h18, 8'h00);
        chk({6'h0, rsp}, {6'h0, RESP_SLVERR}, "unmapped read");
        bus(1'b1, 8'h18, 8'h55);
        chk({6'h0, rsp}, {6'h0, RESP_SLVERR}, "unmapped write");
        bus(1'b1, ADDR_IRQ_EN, 8'h01);
        bus(1'b0, ADDR_IRQ_EN, 8'h00);
        chk(rdat, 8'h01, "irq enable");
        $display("test registers finished");
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, ADDR_CTRL, 8'h20 | 8'(m));
            chk({7'h0, pins_to_gpio}, 8'h00, "gpio enabled");
            peer_u.load(8'h3c ^ 8'(m));
            e0 = edges;
            bus(1'b1, ADDR_BUF, 8'ha5 + 8'(m));
            if (m == 2) begin
                bus(1'b1, ADDR_BUF, 8'hff);
                bus(1'b0, ADDR_CTRL, 8'h00);
                chk(rdat, 8'ha2, "collision flag");
                bus(1'b1, ADDR_CTRL, 8'h22);
            end
            wait_idle();
            chk(8'(edges - e0), 8'd16, "sck edges");
            chk(8'(lastgap), gaps[m], "half period");
            chk({7'h0, sck_out}, 8'h00, "sck idle low");
            chk(peer_u.rx, 8'ha5 + 8'(m), "peer byte");
            bus(1'b0, ADDR_CTRL, 8'h00);
            chk(rdat, 8'h20 | 8'(m), "master overflow");
            if (m != 0) begin
                bus(1'b0, ADDR_BUF, 8'h00);
                chk(rdat, 8'h3c ^ 8'(m), "master byte");
            end else begin
                chk({7'h0, irq}, 8'h01, "irq raised");
                bus(1'b1, ADDR_IRQ_EN, 8'h00);
                chk({7'h0, irq}, 8'h00, "irq masked");
                bus(1'b1, ADDR_IRQ_CLR, 8'h1f);
                bus(1'b0, ADDR_IRQ_STAT, 8'h00);
                chk(rdat, 8'h00, "irq cleared");
            end
        end
        bus(1'b0, ADDR_IRQ_STAT, 8'h00);
        chk(rdat & 8'h04, 8'h04, "collision event");
        bus(1'b1, ADDR_CTRL, 8'h30);
        @(posedge clk);
        chk({7'h0, sck_out}, 8'h01, "sck idle high");
        $display("test master finished");
        bus(1'b1, ADDR_CTRL, 8'h24);
        peer_u.frame(8'h96);
        bus(1'b0, ADDR_BUF, 8'h00);
        chk(rdat, 8'h96, "slave byte");
        bus(1'b1, ADDR_CTRL, 8'h25);
        peer_u.frame(8'h5a);
        peer_u.frame(8'hc3);
        bus(1'b0, ADDR_CTRL, 8'h00);
        chk(rdat, 8'h65, "overflow flag");
        bus(1'b0, ADDR_BUF, 8'h00);
        chk(rdat, 8'h5a, "older byte kept");
        $display("test slave finished");
        foreach (i2c_modes[i]) begin
            bus(1'b1, ADDR_CTRL, 8'h20 | i2c_modes[i]);
            bus(1'b0, ADDR_CTRL, 8'h00);
            chk(rdat, 8'h20 | i2c_modes[i], "mode readback");
            chk({5'h0, sda_oe, sck_oe, sck_out}, 8'h02, "clock held");
            bus(1'b1, ADDR_CTRL, 8'h30 | i2c_modes[i]);
            chk({7'h0, sck_oe}, 8'h00, "clock released");
        end
        peer_u.i2c(8'h69);
        peer_u.i2c(8'h1e);
        bus(1'b0, ADDR_CTRL, 8'h00);
        chk(rdat, 8'h7e, "i2c overflow");
        bus(1'b0, ADDR_BUF, 8'h00);
        chk(rdat, 8'h69, "i2c byte kept");
        bus(1'b1, ADDR_CTRL, 8'h00);
        chk({5'h0, pins_to_gpio, sck_oe, sdo_oe}, 8'h04, "pins returned");
        $display("test modes finished");
        give_verdict();
    end
endmodule : sync_serial_port_control_tb
`default_nettype wire
